// [core/paged_memory_map_decoder.sv]
// Purpose: Decodes processor and paged digital-interface accesses to regions.
// Assumes: Host holds processor in reset before paged accesses.
// Notes:   Outputs registered, one cycle after the request.
`timescale 1ns/100ps
`default_nettype none
module paged_memory_map_decoder
   import memory_map_pkg::*;
(
   input  wire logic        clock,          // System clock
   input  wire logic        rst,            // Synchronous reset, active high
   input  wire logic [7:0]  boot_region_swap, // Swap setting, zero is normal map
   input  wire logic        if_select,      // Digital interface enabled
   input  wire logic        cpu_reset,      // Processor held in reset
   input  wire logic        cpu_valid,      // Processor access request
   input  wire logic [31:0] cpu_addr,       // Processor byte address
   input  wire logic        di_valid,       // Interface access request
   input  wire logic        di_write,       // Interface access is a write
   input  wire logic [7:0]  di_page,        // Interface page number
   input  wire logic [7:0]  di_offset,      // Byte offset within page
   input  wire logic [5:0]  boot_page_sel,  // Page select for boot regions
   input  wire logic [3:0]  dw_page_sel,    // Page select for data/waveform RAM
   output logic             out_valid,      // Decoded access valid
   output region_t          out_region,     // Target region
   output logic [12:0]      out_offset,     // Byte offset within region
   output logic             out_write,      // Write access
   output logic             out_from_di,    // Access came from the interface
   output logic             out_error       // Unmapped or refused access
);
   map_req_if req ();

   // ==========================================================
   // Processor path
   wire swap_on = boot_region_swap != SWAP_OFF;
   assign req.addr = cpu_addr;
   assign req.swap = swap_on;

   region_classifier u_classify (
      .bus (req.classifier)
   );

   // ==========================================================
   // Interface path
   // Interface accesses count only once the host has taken the processor
   wire di_enabled = if_select && cpu_reset;
   wire di_take    = di_valid && di_enabled;
   wire pg_csr     = (di_page == PAGE_CSR_A) || (di_page == PAGE_CSR_B) ||
                     (di_page == PAGE_CSR_C);
   wire dw_is_wave = dw_page_sel >= 4'(DATA_PAGES);
   wire dw_inrange = {28'h0, dw_page_sel} < (DATA_PAGES + WAVE_PAGES);
   wire [3:0] wave_pg = dw_page_sel - 4'(DATA_PAGES);
   wire [12:0] boot_off = {boot_page_sel[4:0], di_offset};
   wire [12:0] dw_off   = dw_is_wave ? {4'h0, wave_pg[0], di_offset}
                                     : {2'b00, dw_page_sel[2:0], di_offset};
   wire boot_inrange = {26'h0, boot_page_sel} < BOOT_PAGES;

   region_t    di_region;
   wire [12:0] di_off =
      (di_page == PAGE_DATAWAVE) ? dw_off :
      pg_csr ? {5'h00, di_offset} : boot_off;
   assign di_region =
      pg_csr ? RGN_CSR :
      (di_page == PAGE_DATAWAVE && dw_inrange) ? (dw_is_wave ? RGN_WAVE : RGN_DATA) :
      (di_page == PAGE_HIGH && boot_inrange) ? (swap_on ? RGN_PROG : RGN_DEVRAM) :
      (di_page == PAGE_LOW && boot_inrange) ? (swap_on ? RGN_DEVRAM : RGN_PROG) :
      RGN_NONE;

   // Program memory is read-only from the interface only in its low home
   wire di_ro_refuse = di_write && (di_page == PAGE_LOW) && !swap_on;

   // ==========================================================
   // Output stage; interface wins while it owns the bus
   wire     use_di   = di_take;
   wire     sel_vld  = use_di || cpu_valid;
   region_t sel_rgn;
   assign sel_rgn = use_di ? di_region : req.region;
   wire [12:0] sel_off = use_di ? di_off : req.offset;
   wire sel_err = (sel_rgn == RGN_NONE) || (use_di && di_ro_refuse);

   always_ff @(posedge clock) begin
      if (rst) begin
         out_valid   <= 1'b0;
         out_region  <= RGN_NONE;
         out_offset  <= 13'h0000;
         out_write   <= 1'b0;
         out_from_di <= 1'b0;
         out_error   <= 1'b0;
      end else begin
         out_valid   <= sel_vld;
         out_region  <= sel_vld ? sel_rgn : RGN_NONE;
         out_offset  <= sel_off;
         out_write   <= use_di && di_write;
         out_from_di <= use_di;
         out_error   <= sel_vld && sel_err;
      end
   end

   // ==========================================================
   // Checks
   a_csr_cpu_map: assert property (@(posedge clock) disable iff (rst)
      (cpu_valid && !di_take && cpu_addr >= CSR_LO && cpu_addr <= CSR_HI)
      |=> (out_region == RGN_CSR))
      else $error("cpu csr address not decoded to csr");
   a_csr_page_map: assert property (@(posedge clock) disable iff (rst)
      (di_take && pg_csr) |=> (out_region == RGN_CSR && out_from_di))
      else $error("csr page not decoded to csr");
   a_devram_normal: assert property (@(posedge clock) disable iff (rst)
      (di_take && di_page == PAGE_HIGH && boot_inrange && !swap_on)
      |=> (out_region == RGN_DEVRAM && out_offset == $past(boot_off)))
      else $error("page 3 not development ram");
   a_wave_cpu_map: assert property (@(posedge clock) disable iff (rst)
      (cpu_valid && !di_take && cpu_addr >= WAVE_LO && cpu_addr <= WAVE_HI)
      |=> (out_region == RGN_WAVE))
      else $error("waveform address misdecoded");
   a_data_cpu_map: assert property (@(posedge clock) disable iff (rst)
      (cpu_valid && !di_take && cpu_addr >= DATA_LO && cpu_addr <= DATA_HI)
      |=> (out_region == RGN_DATA && !out_error))
      else $error("data address misdecoded");
   a_prog_readonly: assert property (@(posedge clock) disable iff (rst)
      (di_take && di_write && di_page == PAGE_LOW && !swap_on) |=> out_error)
      else $error("program memory write not refused");
   a_swap_places: assert property (@(posedge clock) disable iff (rst)
      (di_take && swap_on && di_page == PAGE_LOW && boot_inrange)
      |=> (out_region == RGN_DEVRAM && !out_error))
      else $error("swapped low page not development ram");
   a_di_gated: assert property (@(posedge clock) disable iff (rst)
      (!cpu_valid && di_valid && !di_enabled) |=> !out_valid)
      else $error("interface access taken while not enabled");
endmodule
`default_nettype wire

// [shared/memory_map_pkg.sv]
// Purpose: Constants and types for the paged memory map decoder.
// Assumes: 32-bit processor addresses, 8-bit page numbers and offsets.
// Notes:   Region bounds are inclusive byte addresses.
package memory_map_pkg;

   // ==========================================================
   // Processor address regions
   localparam logic [31:0] CSR_LO       = 32'h4000_0200;
   localparam logic [31:0] CSR_HI       = 32'h4000_05ff;
   localparam logic [31:0] HIGH_BOOT_LO = 32'h2100_0000;
   localparam logic [31:0] HIGH_BOOT_HI = 32'h2100_1fff;
   localparam logic [31:0] WAVE_LO      = 32'h2000_0800;
   localparam logic [31:0] WAVE_HI      = 32'h2000_09ff;
   localparam logic [31:0] DATA_LO      = 32'h2000_0000;
   localparam logic [31:0] DATA_HI      = 32'h2000_07ff;
   localparam logic [31:0] LOW_BOOT_LO  = 32'h0000_0000;
   localparam logic [31:0] LOW_BOOT_HI  = 32'h0000_1fff;

   // ==========================================================
   // Digital-interface page numbers
   localparam logic [7:0] PAGE_CSR_A    = 8'h00;
   localparam logic [7:0] PAGE_CSR_B    = 8'h02;
   localparam logic [7:0] PAGE_CSR_C    = 8'h07;
   localparam logic [7:0] PAGE_DATAWAVE = 8'h01;
   localparam logic [7:0] PAGE_HIGH     = 8'h03;
   localparam logic [7:0] PAGE_LOW      = 8'h04;

   // Page counts and page-select field widths
   localparam int BOOT_PAGES     = 32;
   localparam int DATA_PAGES     = 8;
   localparam int WAVE_PAGES     = 2;
   localparam int BOOT_SEL_W     = 6;
   localparam int DATAWAVE_SEL_W = 4;
   localparam logic [7:0] SWAP_OFF = 8'h00;

   typedef enum logic [2:0] {
      RGN_NONE,
      RGN_CSR,
      RGN_DEVRAM,
      RGN_WAVE,
      RGN_DATA,
      RGN_PROG
   } region_t;

endpackage

// [shared/map_req_if.sv]
// Purpose: Carries one decoded request between decoder and classifier.
// Assumes: Single clock domain.
// Notes:   Classifier is purely combinational.
`timescale 1ns/100ps
`default_nettype none
interface map_req_if;
   import memory_map_pkg::*;
   logic [31:0] addr;      // Processor byte address
   logic        swap;      // Boot-region swap active
   region_t     region;    // Decoded region
   logic [12:0] offset;    // Byte offset inside region
   modport requester (output addr, output swap, input region, input offset);
   modport classifier (input addr, input swap, output region, output offset);
endinterface
`default_nettype wire

// [core/region_classifier.sv]
// Purpose: Classifies a processor address into a memory region.
// Assumes: Bounds inclusive; unmatched addresses give RGN_NONE.
// Notes:   Swap exchanges program memory and development RAM placement.
`timescale 1ns/100ps
`default_nettype none
module region_classifier
   import memory_map_pkg::*;
(
   map_req_if.classifier bus  // Address in, region out
);
   wire in_csr  = (bus.addr >= CSR_LO) && (bus.addr <= CSR_HI);
   wire in_high = (bus.addr >= HIGH_BOOT_LO) && (bus.addr <= HIGH_BOOT_HI);
   wire in_wave = (bus.addr >= WAVE_LO) && (bus.addr <= WAVE_HI);
   wire in_data = (bus.addr >= DATA_LO) && (bus.addr <= DATA_HI);
   wire in_low  = bus.addr <= LOW_BOOT_HI;
   wire [31:0] base = in_csr  ? CSR_LO  : in_high ? HIGH_BOOT_LO :
                      in_wave ? WAVE_LO : in_data ? DATA_LO : LOW_BOOT_LO;
   wire [31:0] diff = bus.addr - base;

   // Swap only moves the two boot regions
   assign bus.region = in_csr  ? RGN_CSR :
                       in_high ? (bus.swap ? RGN_PROG : RGN_DEVRAM) :
                       in_wave ? RGN_WAVE :
                       in_data ? RGN_DATA :
                       in_low  ? (bus.swap ? RGN_DEVRAM : RGN_PROG) :
                       RGN_NONE;
   assign bus.offset = diff[12:0];
endmodule
`default_nettype wire

// [test/host_model.sv]
// Purpose: Behavioural host on the paged digital interface.
// Assumes: Bench calls the tasks at a rising clock edge.
// Notes:   Released lines show the inverse of the last value, except di_valid, which drops low.
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input  wire logic       clock,     // System clock
   output logic            if_select, // Interface select bit
   output logic            cpu_reset, // Processor reset bit
   output logic            di_valid,  // Request
   output logic            di_write,  // Write access
   output logic [7:0]      di_page,   // Page number
   output logic [7:0]      di_offset  // Byte offset
);
   initial begin
      {if_select, cpu_reset, di_valid, di_write, di_page, di_offset} = '0;
   end
   // Select first, then hold the processor in reset
   task automatic enable();
      @(posedge clock);
      if_select <= 1'b1;
      @(posedge clock);
      cpu_reset <= 1'b1;
   endtask
   task automatic put(input logic v, w, input logic [7:0] p, o);
      di_valid <= v;
      di_write <= w;
      di_page <= p;
      di_offset <= o;
   endtask
endmodule
`default_nettype wire

// [test/tb_paged_memory_map_decoder.sv]
// Purpose: Self-checking bench for the paged memory map decoder.
// Assumes: One request, then one idle cycle with scrambled lines.
// Notes:   Region codes follow region_t order.
`timescale 1ns/100ps
`default_nettype none
module tb_paged_memory_map_decoder;
   import memory_map_pkg::*;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        cpu_valid = 1'b0;
   logic [31:0] cpu_addr = '0;
   logic [7:0]  boot_region_swap = '0;
   logic [5:0]  boot_page_sel = '0;
   logic [3:0]  dw_page_sel = '0;
   wire logic   if_select, cpu_reset, di_valid, di_write;
   wire logic [7:0] di_page, di_offset;
   logic        out_valid, out_write, out_from_di, out_error;
   region_t     out_region;
   logic [12:0] out_offset;
   int          bad_count = 0, n_compared = 0, cyc = 0;
   logic [31:0] rs = 32'h41, x;
   logic [7:0]  sw;
   logic [5:0]  bs;
   logic [3:0]  dw;
   logic [31:0] lo [5] = '{CSR_LO, HIGH_BOOT_LO, WAVE_LO, DATA_LO, LOW_BOOT_LO};
   logic [31:0] hi [5] = '{CSR_HI, HIGH_BOOT_HI, WAVE_HI, DATA_HI, LOW_BOOT_HI};
   host_model host (.clock, .if_select, .cpu_reset, .di_valid, .di_write, .di_page, .di_offset);
   paged_memory_map_decoder uut (.clock, .rst, .boot_region_swap, .if_select, .cpu_reset,
      .cpu_valid, .cpu_addr, .di_valid, .di_write, .di_page, .di_offset, .boot_page_sel,
      .dw_page_sel, .out_valid, .out_region, .out_offset, .out_write, .out_from_di, .out_error);
   always #5 clock = ~clock;
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp(input logic [12:0] g, x);
      n_compared++;
      if (g !== x) begin
         bad_count++;
         $display("mismatch t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   // ==========================================================
   // Reference model, from the map tables
   task automatic check(input logic dv, w, input logic [7:0] p, o, input logic cv,
                        input logic [31:0] a);
      int r, off, s, d;
      s = (sw != 8'h00);
      d = dv && if_select && cpu_reset;
      r = 0;
      off = 0;
      if (d) begin
         case (p)
            8'h00, 8'h02, 8'h07: r = 1;
            8'h01: r = (dw < 8) ? 4 : (dw < 10) ? 3 : 0;
            // Page selects past the last boot page reach nothing
            8'h03: r = (bs >= BOOT_PAGES) ? 0 : s ? 5 : 2;
            8'h04: r = (bs >= BOOT_PAGES) ? 0 : s ? 2 : 5;
            default: r = 0;
         endcase
         off = o + 256 * ((p == 8'h01) ? dw % 8 : (p == 8'h03 || p == 8'h04) ? bs : 0);
      end else if (cv) begin
         for (int i = 0; i < 5; i++)
            if (a >= lo[i] && a <= hi[i]) begin
               r = (i == 1) ? (s ? 5 : 2) : (i == 4) ? (s ? 2 : 5) : i + 1;
               off = int'(a - lo[i]);
            end
      end
      cmp(out_valid, d || cv);
      if (d || cv) begin
         cmp(out_region, r);
         cmp(out_error, r == 0 || (d && p == 8'h04 && !s && w));
         cmp(out_from_di, d);
         cmp(out_write, d && w);
         if (r != 0) cmp(out_offset, off);
      end else begin
         cmp(out_region, RGN_NONE);
         cmp(out_error, 1'b0);
         cmp(out_from_di, 1'b0);
         cmp(out_write, 1'b0);
      end
   endtask
   task automatic acc(input logic dv, w, input logic [7:0] p, o, input logic cv,
                      input logic [31:0] a);
      @(posedge clock);
      host.put(dv, w, p, o);
      cpu_valid <= cv;
      cpu_addr <= a;
      boot_region_swap <= sw;
      boot_page_sel <= bs;
      dw_page_sel <= dw;
      @(posedge clock);
      host.put(1'b0, ~w, ~p, ~o);
      cpu_valid <= 1'b0;
      cpu_addr <= ~a;
      #1;
      check(dv, w, p, o, cv, a);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      sw = 8'h00;
      bs = '0;
      dw = '0;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      acc(1'b1, 1'b0, 8'h02, 8'h10, 1'b0, '0);
      host.enable();
      for (int k = 0; k < 3; k++) begin
         sw = (k == 1) ? 8'h01 : (k == 2) ? 8'h80 : 8'h00;
         for (int i = 0; i < 5; i++) begin
            acc(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, lo[i]);
            acc(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, hi[i]);
            acc(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, hi[i] + 1);
            acc(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, lo[i] - 1);
         end
         for (int n = 0; n < 120; n++) begin
            x = rnd();
            bs = x[5:0];
            dw = x[9:6];
            acc(x[26] | x[27], x[10], {4'h0, x[14:11]}, x[23:16], x[25],
                lo[n % 5] + (x & 32'h1ff));
         end
      end
      // Mid-run reset with requests pending: outputs must clear
      @(posedge clock);
      rst <= 1'b1;
      host.put(1'b1, 1'b1, 8'h03, 8'h55);
      cpu_valid <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      cmp(out_valid, 1'b0);
      cmp(out_region, RGN_NONE);
      cmp(out_error, 1'b0);
      cmp(out_write, 1'b0);
      @(posedge clock);
      rst <= 1'b0;
      host.put(1'b0, 1'b0, 8'h00, 8'h00);
      cpu_valid <= 1'b0;
      acc(1'b1, 1'b1, 8'h03, 8'h20, 1'b0, '0);
      acc(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, CSR_LO);
      conclude();
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         conclude();
      end
   end
endmodule
`default_nettype wire
